// >>> pkg/laser_ctrl_pkg.sv
// constants, register map and state types of the laser driver control block
package laser_ctrl_pkg;

	// clock and soft-start timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SOFT_START_NS = 150_000;
	localparam int unsigned SOFT_START_CYC =
		SOFT_START_NS / (1_000_000_000 / CLK_HZ);
	localparam int unsigned RAMP_STEPS = 256;
	localparam int unsigned RAMP_DIV = SOFT_START_CYC / RAMP_STEPS;
	localparam int unsigned DIV_W = 4;
	localparam int unsigned LEVEL_W = 12;
	localparam logic [11:0] RAMP_INC = 12'h010;

	// temperature thresholds, signed degrees celsius
	localparam logic signed [7:0] T_WARN_ON = 8'sh3c;
	localparam logic signed [7:0] T_WARN_OFF = 8'sh3a;
	localparam logic signed [7:0] T_SHUTDOWN = 8'sh50;
	localparam logic signed [7:0] T_RESTART = 8'sh3a;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATE = 8'h04;
	localparam logic [7:0] ADDR_LIMITS = 8'h08;
	localparam logic [7:0] ADDR_THERM = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_SETPOINT = 8'h18;
	localparam logic [7:0] ADDR_LEVEL = 8'h1c;

	// control register fields
	localparam int unsigned CTRL_W = 5;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_CUR_INT = 1;
	localparam int unsigned CTRL_EN_INT = 2;
	localparam int unsigned CTRL_ILK_DENY = 3;
	localparam int unsigned CTRL_NTC_DENY = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;

	// state word fields
	localparam int unsigned ST_POWERED = 0;
	localparam int unsigned ST_STARTED = 1;
	localparam int unsigned ST_CUR_INT = 2;
	localparam int unsigned ST_EN_INT = 4;
	localparam int unsigned ST_NTC_DENY = 6;
	localparam int unsigned ST_ILK_DENY = 7;
	localparam int unsigned ST_FAULT = 8;
	localparam int unsigned ST_WARN = 9;
	localparam int unsigned ST_LOCKOUT = 10;
	localparam int unsigned ST_OT_STOP = 11;

	// limits register: low in [7:0], high in [15:8]
	localparam logic [7:0] LIM_LO_RST = 8'h0a;
	localparam logic [7:0] LIM_HI_RST = 8'h32;
	localparam logic [11:0] SETPOINT_RST = 12'h000;

	// interrupt status bits
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_FAULT = 0;
	localparam int unsigned IRQ_WARN = 1;
	localparam int unsigned IRQ_LOCK = 2;
	localparam int unsigned IRQ_ILK = 3;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RAMP = 2'b01,
		ST_ON = 2'b11,
		ST_SHUT = 2'b10
	} run_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} bus_phase_t;

	typedef struct packed {
		run_state_t st;
		logic [LEVEL_W-1:0] level;
		logic [DIV_W-1:0] div;
		logic fault;
		logic ot_stop;
		logic warn;
		logic lock_prev;
		logic ilk_prev;
		logic [CTRL_W-1:0] ctrl;
		logic [7:0] lim_lo;
		logic [7:0] lim_hi;
		logic [LEVEL_W-1:0] setpt;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		bus_phase_t ph;
		logic [31:0] rdata;
	} drv_state_t;

endpackage

// >>> logic/bit_sync.sv
// two-stage synchroniser for a group of level inputs
`timescale 1ns/1ns
module bit_sync
	import laser_ctrl_pkg::*;
#(
	parameter int unsigned WIDTH = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] reset_val,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] hold_q;

	if (WIDTH < 1) begin : g_chk
		$error("bit_sync needs WIDTH of at least one");
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= '0;
			hold_q <= '0;
		end else begin
			meta_q <= async_in ^ reset_val;
			hold_q <= meta_q;
		end
	end

	// flops hold the offset from reset_val, so reset shows reset_val
	assign sync_out = hold_q ^ reset_val;

endmodule

// >>> logic/laser_driver_ctrl.sv
// laser driver control, protection and register slave on ahb-lite
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module laser_driver_ctrl
	import laser_ctrl_pkg::*;
#(
	parameter int unsigned RAMP_DIV_P = RAMP_DIV
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic enable_in,
	input wire logic interlock_n_in,
	input wire logic over_current_in,
	input wire logic signed [7:0] board_temp,
	input wire logic signed [7:0] thermistor_lockout_temp,
	input wire logic [LEVEL_W-1:0] current_set_in,
	output logic output_on,
	output logic [LEVEL_W-1:0] current_cmd,
	output logic clamp_on,
	output logic clamp_fault,
	output logic ot_warning,
	output logic irq
);

	drv_state_t q;
	drv_state_t d;
	logic [1:0] pins_sync;
	logic en_pin;
	logic ilk_n_pin;
	logic en;
	logic ilk_ok;
	logic lock;
	logic trip;
	logic permit;
	logic tick;
	logic [LEVEL_W-1:0] target;
	logic [LEVEL_W:0] step_sum;
	logic addr_sel;
	logic [31:0] state_word;

	if (RAMP_DIV_P < 1 || RAMP_DIV_P > 2 ** DIV_W) begin : g_chk
		$error("RAMP_DIV_P must lie between 1 and 2**DIV_W");
	end

	////////////////////////////////////////////////////////////////////////
	// input synchronisers, interlock idles open (high)
	bit_sync #(.WIDTH(2)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({interlock_n_in, enable_in}),
		.reset_val(2'b10),
		.sync_out(pins_sync)
	);
	assign en_pin = pins_sync[0];
	assign ilk_n_pin = pins_sync[1];

	////////////////////////////////////////////////////////////////////////
	// protection and permit terms
	always_comb begin
		en = q.ctrl[CTRL_EN_INT] ? q.ctrl[CTRL_START] : en_pin;
		ilk_ok = q.ctrl[CTRL_ILK_DENY] | ~ilk_n_pin;
		lock = ~q.ctrl[CTRL_NTC_DENY] &
			((thermistor_lockout_temp < $signed(q.lim_lo)) |
			(thermistor_lockout_temp > $signed(q.lim_hi)));
		trip = over_current_in | (board_temp > T_SHUTDOWN);
		permit = ilk_ok & ~lock & ~q.ot_stop;
		target = q.ctrl[CTRL_CUR_INT] ? q.setpt : current_set_in;
		tick = (q.div == DIV_W'(RAMP_DIV_P - 1));
		step_sum = {1'b0, q.level} + {1'b0, RAMP_INC};
		addr_sel = hsel & htrans[1] & hready;
		state_word = '0;
		state_word[ST_POWERED] = 1'b1;
		state_word[ST_STARTED] = q.st[0];
		state_word[ST_CUR_INT] = q.ctrl[CTRL_CUR_INT];
		state_word[ST_EN_INT] = q.ctrl[CTRL_EN_INT];
		state_word[ST_NTC_DENY] = q.ctrl[CTRL_NTC_DENY];
		state_word[ST_ILK_DENY] = q.ctrl[CTRL_ILK_DENY];
		state_word[ST_FAULT] = q.fault;
		state_word[ST_WARN] = q.warn;
		state_word[ST_LOCKOUT] = lock;
		state_word[ST_OT_STOP] = q.ot_stop;
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [IRQ_W-1:0] ev;
		logic [31:0] rd;
		d = q;
		ev = '0;
		rd = '0;

		// thermal hysteresis
		if (board_temp > T_WARN_ON) begin
			d.warn = 1'b1;
		end else if (board_temp < T_WARN_OFF) begin
			d.warn = 1'b0;
		end
		if (board_temp > T_SHUTDOWN) begin
			d.ot_stop = 1'b1;
		end else if (board_temp <= T_RESTART) begin
			d.ot_stop = 1'b0;
		end
		if (trip) begin
			d.fault = 1'b1;
		end

		// run sequence
		case (q.st)
			ST_OFF: begin
				d.level = '0;
				d.div = '0;
				if (en && permit) begin
					d.st = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (!en || !permit) begin
					d.st = ST_OFF;
					d.level = '0;
				end else if (tick) begin
					d.div = '0;
					if (step_sum >= {1'b0, target}) begin
						d.level = target;
						d.st = ST_ON;
					end else begin
						d.level = step_sum[LEVEL_W-1:0];
					end
				end else begin
					d.div = q.div + DIV_W'(1);
				end
			end
			ST_ON: begin
				if (!en || !permit) begin
					d.st = ST_OFF;
					d.level = '0;
				end else begin
					d.level = target;
				end
			end
			default: begin
				d.level = '0;
			end
		endcase
		if (trip || q.fault) begin
			d.st = ST_SHUT;
			d.level = '0;
		end

		// interrupt events
		ev[IRQ_FAULT] = trip & ~q.fault;
		ev[IRQ_WARN] = d.warn & ~q.warn;
		ev[IRQ_LOCK] = lock & ~q.lock_prev;
		ev[IRQ_ILK] = ~ilk_ok & q.ilk_prev;
		d.lock_prev = lock;
		d.ilk_prev = ilk_ok;

		// bus address phase and read data
		d.ph = '{valid: addr_sel, write: hwrite, addr: haddr[7:0]};
		if (addr_sel && !hwrite) begin
			if (haddr[7:0] == ADDR_CTRL) begin
				rd = 32'(q.ctrl);
			end else if (haddr[7:0] == ADDR_STATE) begin
				rd = state_word;
			end else if (haddr[7:0] == ADDR_LIMITS) begin
				rd = {16'h0000, q.lim_hi, q.lim_lo};
			end else if (haddr[7:0] == ADDR_THERM) begin
				rd = 32'(unsigned'(thermistor_lockout_temp));
			end else if (haddr[7:0] == ADDR_IRQ_STAT) begin
				rd = 32'(q.irq_stat);
			end else if (haddr[7:0] == ADDR_IRQ_MASK) begin
				rd = 32'(q.irq_mask);
			end else if (haddr[7:0] == ADDR_SETPOINT) begin
				rd = 32'(q.setpt);
			end else if (haddr[7:0] == ADDR_LEVEL) begin
				rd = 32'(q.level);
			end
			d.rdata = rd;
		end
		if (addr_sel && !hwrite && haddr[7:0] == ADDR_IRQ_STAT) begin
			d.irq_stat = ev;
		end else begin
			d.irq_stat = q.irq_stat | ev;
		end

		// bus data phase writes
		if (q.ph.valid && q.ph.write) begin
			if (q.ph.addr == ADDR_CTRL) begin
				d.ctrl = hwdata[CTRL_W-1:0];
			end else if (q.ph.addr == ADDR_LIMITS) begin
				d.lim_lo = hwdata[7:0];
				d.lim_hi = hwdata[15:8];
			end else if (q.ph.addr == ADDR_IRQ_MASK) begin
				d.irq_mask = hwdata[IRQ_W-1:0];
			end else if (q.ph.addr == ADDR_SETPOINT) begin
				d.setpt = hwdata[LEVEL_W-1:0];
			end
		end
		d.irq = |(d.irq_stat & d.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// state register, power-on defaults
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q.st <= ST_OFF;
			q.level <= '0;
			q.div <= '0;
			q.fault <= 1'b0;
			q.ot_stop <= 1'b0;
			q.warn <= 1'b0;
			q.lock_prev <= 1'b0;
			q.ilk_prev <= 1'b0;
			q.ctrl <= CTRL_RST;
			q.lim_lo <= LIM_LO_RST;
			q.lim_hi <= LIM_HI_RST;
			q.setpt <= SETPOINT_RST;
			q.irq_stat <= '0;
			q.irq_mask <= '0;
			q.irq <= 1'b0;
			q.ph <= '0;
			q.rdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			q <= d;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = q.rdata;
	assign output_on = q.st[0];
	assign current_cmd = q.level;
	assign clamp_on = q.fault;
	assign clamp_fault = q.fault;
	assign ot_warning = q.warn;
	assign irq = q.irq;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_ENABLE_OFF: assert property (
		!en |=> !output_on && current_cmd == '0)
		else $error("output on while enable low");
	AST_RAMP_START: assert property (
		q.st == ST_OFF && en && permit && !trip && !q.fault
		|=> q.st == ST_RAMP && current_cmd == '0)
		else $error("soft start did not begin from zero");
	AST_PULSE_FOLLOW: assert property (
		$fell(en) && q.st[0] |=> !output_on)
		else $error("output did not follow falling enable");
	AST_FAULT_FLAG: assert property (
		trip |=> clamp_fault && clamp_on)
		else $error("clamp fault not raised on trip");
	AST_SHUT_OFF: assert property (
		clamp_fault |-> !output_on && current_cmd == '0)
		else $error("output live during shutdown");
	AST_IGNORE_EN: assert property (
		clamp_fault && $rose(en) |=> q.st == ST_SHUT [*2])
		else $error("enable acted during shutdown");
	AST_LATCHED: assert property (
		clamp_fault |=> clamp_fault)
		else $error("clamp fault cleared without reset");
	AST_INTERLOCK: assert property (
		ilk_n_pin && !q.ctrl[CTRL_ILK_DENY] |=> !output_on)
		else $error("output on with interlock open");
	AST_WARN_ON: assert property (
		board_temp > T_WARN_ON |=> ot_warning)
		else $error("warning not raised above threshold");
	AST_WARN_HOLD: assert property (
		ot_warning && board_temp >= T_WARN_OFF |=> ot_warning)
		else $error("warning dropped inside hysteresis");
	AST_OT_HOLD: assert property (
		q.ot_stop && board_temp > T_RESTART |=> q.ot_stop && !output_on)
		else $error("restart before cooling to restart level");
	AST_LOCKOUT: assert property (
		lock |=> !output_on)
		else $error("output on with thermistor out of range");

endmodule

// >>> tb/host_ctrl_model.sv
// host controller model driving enable and interlock pins
`timescale 1ns/1ns
module host_ctrl_model (
	input wire logic hclk,
	input wire logic run,
	input wire logic lock_open,
	input wire logic [7:0] pulse_half,
	output logic enable_in,
	output logic interlock_n_in
);
	logic [7:0] cnt_q;
	always @(posedge hclk) begin
		interlock_n_in <= lock_open;
		if (!run) begin
			enable_in <= 1'h0;
			cnt_q <= 8'h00;
		end else if (pulse_half == 8'h00) begin
			enable_in <= 1'h1;
		end else if (cnt_q + 8'h01 >= pulse_half) begin
			enable_in <= ~enable_in;
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule

// >>> tb/test_laser_driver_protection_control.sv
// self-checking testbench of the laser driver control block
`timescale 1ns/1ns
module test_laser_driver_protection_control import laser_ctrl_pkg::*;;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error %0t got %h exp %h", $time, g, e); end end
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, enable_in, interlock_n_in, w;
	logic over_current_in = 1'h0, run = 1'h0, lock_open = 1'h1;
	logic signed [7:0] board_temp = 8'h19, thermistor_lockout_temp = 8'h19;
	logic [LEVEL_W-1:0] current_set_in = 12'h0, current_cmd, tgt;
	logic [7:0] pulse_half = 8'h0;
	logic output_on, clamp_on, clamp_fault, ot_warning, irq;
	logic [31:0] seed = 32'h1102d3be;
	logic signed [7:0] tl [6] = '{8'h33, 8'h32, 8'h09, 8'h0a, 8'h7f, 8'h19};
	logic signed [7:0] wt [9] = '{8'h3d, 8'h3b, 8'h39, 8'h3c, 8'h3b,
		8'h3d, 8'h3c, 8'h3a, 8'h39};
	int error_cnt = 0, checked = 0;
	////////////////////////////////////////
	always #25 hclk = ~hclk;
	laser_driver_ctrl #(.RAMP_DIV_P(1)) u_dut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .enable_in, .interlock_n_in, .over_current_in,
		.board_temp, .thermistor_lockout_temp, .current_set_in, .output_on,
		.current_cmd, .clamp_on, .clamp_fault, .ot_warning, .irq);
	host_ctrl_model u_host (.hclk, .run, .lock_open, .pulse_half, .enable_in,
		.interlock_n_in);
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic exp_warn(input logic p, input logic signed [7:0] t);
		return (t > T_WARN_ON) ? 1'h1 : ((t < T_WARN_OFF) ? 1'h0 : p);
	endfunction
	function logic in_lim(input logic signed [7:0] t);
		return t >= $signed(LIM_LO_RST) && t <= $signed(LIM_HI_RST);
	endfunction
	task settle(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		rd = hrdata;
	endtask
	task wait_on(input logic v);
		for (int i = 0; i < 60 && output_on !== v; i++) settle(1);
	endtask
	task ramp_to(input logic [11:0] t);
		logic bad;
		bad = 1'h0;
		for (int i = 0; i < 400 && current_cmd !== t; i++) begin
			settle(1);
			bad |= (current_cmd > t);
		end
		`CHK({bad, current_cmd}, {1'h0, t})
	endtask
	task tally_and_finish();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge hclk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		settle(2);
		`CHK({output_on, clamp_fault, ot_warning, irq}, 4'h0)
		repeat (14) @(posedge hclk);
		hresetn <= 1'h1;
		ahb(1'h0, ADDR_CTRL, 32'h0);
		`CHK(rd[4:0], CTRL_RST)
		ahb(1'h0, ADDR_STATE, 32'h0);
		`CHK({rd[7:6], rd[4], rd[2], rd[0]}, 5'h01)
		ahb(1'h0, ADDR_LIMITS, 32'h0);
		`CHK(rd[15:0], {LIM_HI_RST, LIM_LO_RST})
		ahb(1'h1, ADDR_IRQ_MASK, 32'h1 << IRQ_LOCK);
		// start and ramp on external setpoint
		tgt = 12'(rnd()) | 12'h100;
		@(posedge hclk);
		current_set_in <= tgt;
		lock_open <= 1'h0;
		run <= 1'h1;
		wait_on(1'h1);
		`CHK({output_on, current_cmd}, {1'h1, 12'h0})
		ramp_to(tgt);
		ahb(1'h0, ADDR_STATE, 32'h0);
		`CHK(rd[ST_STARTED], 1'h1)
		// internal setpoint chosen by host
		tgt = 12'(rnd()) | 12'h100;
		ahb(1'h1, ADDR_SETPOINT, {20'h0, tgt});
		ahb(1'h1, ADDR_CTRL, 32'h1 << CTRL_CUR_INT);
		ahb(1'h0, ADDR_STATE, 32'h0);
		`CHK(rd[ST_CUR_INT], 1'h1)
		ramp_to(tgt);
		ahb(1'h1, ADDR_CTRL, 32'h0);
		// interlock open then closed
		@(posedge hclk);
		lock_open <= 1'h1;
		wait_on(1'h0);
		`CHK(output_on, 1'h0)
		@(posedge hclk);
		lock_open <= 1'h0;
		wait_on(1'h1);
		`CHK(output_on, 1'h1)
		// thermistor range boundaries
		tl[4] = 8'h33 + 8'(rnd() % 32'd77);
		for (int k = 0; k < 6; k++) begin
			@(posedge hclk);
			thermistor_lockout_temp <= tl[k];
			settle(6);
			`CHK(output_on, in_lim(tl[k]))
			ahb(1'h0, ADDR_THERM, 32'h0);
			`CHK(rd[7:0], tl[k])
		end
		`CHK(irq, 1'h1)
		ahb(1'h0, ADDR_IRQ_STAT, 32'h0);
		`CHK(rd[IRQ_LOCK], 1'h1)
		settle(2);
		`CHK(irq, 1'h0)
		// pulsed enable
		@(posedge hclk);
		pulse_half <= 8'(8 + rnd() % 16);
		repeat (3) begin
			@(posedge enable_in);
			settle(5);
			`CHK(output_on, 1'h1)
			@(negedge enable_in);
			settle(5);
			`CHK(output_on, 1'h0)
		end
		@(posedge hclk);
		pulse_half <= 8'h0;
		// warning hysteresis, event masked
		w = 1'h0;
		for (int k = 0; k < 9; k++) begin
			@(posedge hclk);
			board_temp <= wt[k];
			settle(4);
			w = exp_warn(w, wt[k]);
			`CHK(ot_warning, w)
		end
		`CHK(irq, 1'h0)
		ahb(1'h0, ADDR_IRQ_STAT, 32'h0);
		`CHK(rd[IRQ_WARN], 1'h1)
		// over-current latch, enable ignored
		@(posedge hclk);
		over_current_in <= 1'h1;
		settle(3);
		`CHK({clamp_fault, clamp_on, output_on}, 3'h6)
		@(posedge hclk);
		over_current_in <= 1'h0;
		run <= 1'h0;
		settle(6);
		@(posedge hclk);
		run <= 1'h1;
		settle(8);
		`CHK({clamp_fault, output_on, current_cmd}, {2'h2, 12'h0})
		@(posedge hclk);
		hresetn <= 1'h0;
		settle(3);
		`CHK(clamp_fault, 1'h0)
		@(posedge hclk);
		hresetn <= 1'h1;
		wait_on(1'h1);
		`CHK(output_on, 1'h1)
		// internal enable, interlock and lockout denied
		ahb(1'h1, ADDR_CTRL, 32'h1c);
		wait_on(1'h0);
		`CHK(output_on, 1'h0)
		@(posedge hclk);
		lock_open <= 1'h1;
		thermistor_lockout_temp <= 8'h7f;
		ahb(1'h1, ADDR_CTRL, 32'h1d);
		wait_on(1'h1);
		`CHK(output_on, 1'h1)
		ahb(1'h0, ADDR_STATE, 32'h0);
		`CHK({rd[7:6], rd[4]}, 3'h7)
		ramp_to(current_set_in);
		ahb(1'h0, ADDR_LEVEL, 32'h0);
		`CHK(rd[11:0], current_set_in)
		`CHK({hreadyout, hresp}, 2'h2)
		// over-temperature shutdown
		@(posedge hclk);
		board_temp <= 8'h50;
		settle(4);
		`CHK(clamp_fault, 1'h0)
		@(posedge hclk);
		board_temp <= 8'h51;
		settle(4);
		`CHK({clamp_fault, clamp_on, output_on}, 3'h6)
		@(posedge hclk);
		board_temp <= 8'h3a;
		settle(4);
		`CHK({clamp_fault, output_on}, 2'h2)
		tally_and_finish();
	end
endmodule
